//--- logic/bsc_pkg.sv
// package for the branch, skip and call control block
package bsc_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] BSC_OFS_CMD = 8'h00;
    localparam logic [7:0] BSC_OFS_OPS = 8'h04;
    localparam logic [7:0] BSC_OFS_FLAGS = 8'h08;
    localparam logic [7:0] BSC_OFS_Z = 8'h0C;
    localparam logic [7:0] BSC_OFS_PC = 8'h10;
    localparam logic [7:0] BSC_OFS_PAGE = 8'h14;
    localparam logic [7:0] BSC_OFS_STACK = 8'h18;
    localparam logic [7:0] BSC_OFS_RES = 8'h1C;
    localparam logic [7:0] BSC_OFS_STATUS = 8'h20;
    localparam logic [7:0] BSC_OFS_IO = 8'h24;

    // ------------------------------------------------------------
    // flag bit positions in the status flags register
    // ------------------------------------------------------------
    localparam int BSC_FLAG_C = 0;
    localparam int BSC_FLAG_Z = 1;
    localparam int BSC_FLAG_N = 2;
    localparam int BSC_FLAG_V = 3;
    localparam int BSC_FLAG_S = 4;
    localparam int BSC_FLAG_H = 5;
    localparam int BSC_FLAG_T = 6;
    localparam int BSC_FLAG_I = 7;

    // ------------------------------------------------------------
    // reset values and cycle figures
    // ------------------------------------------------------------
    localparam logic [21:0] BSC_PC_RST = 22'h000000;
    localparam logic [7:0] BSC_FLAGS_RST = 8'h00;
    localparam logic [2:0] BSC_CYC_ONE = 3'h1;
    localparam logic [2:0] BSC_CYC_TWO = 3'h2;
    localparam logic [2:0] BSC_CYC_THREE = 3'h3;
    localparam logic [2:0] BSC_CYC_FOUR = 3'h4;
    localparam logic [21:0] BSC_PC_STEP = 22'h000001;
    localparam logic [21:0] BSC_PC_SKIP1 = 22'h000002;
    localparam logic [21:0] BSC_PC_SKIP2 = 22'h000003;

    // ------------------------------------------------------------
    // operation codes written to the command register
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        BSC_OP_NONE = 6'h00,
        BSC_OP_INDIRECT_CALL = 6'h01,
        BSC_OP_EXT_INDIRECT_CALL = 6'h02,
        BSC_OP_REL_CALL = 6'h03,
        BSC_OP_DIRECT_CALL = 6'h04,
        BSC_OP_SUB_EXIT = 6'h05,
        BSC_OP_IRQ_EXIT = 6'h06,
        BSC_OP_CMP_SKIP_EQ = 6'h07,
        BSC_OP_CMP_REGS = 6'h08,
        BSC_OP_CMP_BORROW = 6'h09,
        BSC_OP_CMP_IMM = 6'h0A,
        BSC_OP_SKIP_REG_CLR = 6'h0B,
        BSC_OP_SKIP_REG_SET = 6'h0C,
        BSC_OP_SKIP_IO_CLR = 6'h0D,
        BSC_OP_SKIP_IO_SET = 6'h0E,
        BSC_OP_BR_FLAG_SET = 6'h0F,
        BSC_OP_BR_FLAG_CLR = 6'h10,
        BSC_OP_BR_SIGNED_GE = 6'h11,
        BSC_OP_BR_SIGNED_LT = 6'h12,
        BSC_OP_COPY_REG = 6'h13,
        BSC_OP_COPY_PAIR = 6'h14
    } bsc_op_t;

    // controller states, gray along idle-busy-done
    typedef enum logic [1:0] {
        BSC_ST_IDLE = 2'b00,
        BSC_ST_BUSY = 2'b01,
        BSC_ST_DONE = 2'b11
    } bsc_state_t;

    // operand word written by software
    typedef struct packed {
        logic [7:0] rd;
        logic [7:0] rr;
        logic [2:0] bit_sel;
        logic next_two_words;
        logic [11:0] k;
    } bsc_ops_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } bsc_apb_req_t;
endpackage

//--- logic/bsc_core.sv
// branch, skip and call control with apb register access
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps

// Summary of operation
// RQ1: indirect call loads pc 15:0 from z, clears pc 21:16, keeps flags, takes 2 or 3 cycles.
// RQ2: extended indirect call loads pc 15:0 from z and 21:16 from the page register in 3 cycles.
// RQ3: compare-skip-equal adds 2 or 3 to pc when rd equals rr, 1 to 3 cycles, flags kept.
// RQ4: register-bit skips skip when the chosen bit is clear or set, 1 to 3 cycles, flags kept.
// RQ5: io-bit skips test one io register bit and skip when clear or set, 2 to 4 cycles.
// RQ6: flag branches test flag s set or clear and jump to pc+k+1, 1 cycle untaken, 2 taken.
// RQ7: carry branches jump on carry set (lower) or clear (same or higher) by k+1 in 1 or 2 cycles.
// RQ8: signed ge branches when n xor v is 0, signed lt when it is 1, 1 or 2 cycles.
// RQ9: half-carry branches jump when h is 1 or 0 by k+1 with flags unchanged.
// RQ10: transfer-bit branches jump when t is 1 or 0 by k+1 in 1 or 2 cycles.
// RQ11: overflow, negative and zero flag branches jump on their flag set or clear.
// RQ12: interrupt-state branches jump when the global enable is 1 or 0, 1 or 2 cycles.
// RQ13: relative call goes to pc+k+1, direct call to k, returns pop pc and irq exit sets i.
// RQ14: compares form rd-rr, minus carry or minus immediate, set z c n v s h, write no register.
// RQ15: register and pair copies finish in one cycle and keep every flag.
module bsc_core
    import bsc_pkg::*;
#(
    parameter int PC_W = 22
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    bsc_apb_req_t req;
    bsc_state_t state_q;
    bsc_op_t op_q;
    bsc_ops_t ops_q;
    logic [7:0] flags_q;
    logic [15:0] z_q;
    logic [5:0] page_q;
    logic [21:0] pc_q;
    logic [21:0] stack_q;
    logic [15:0] res_q;
    logic [7:0] io_q;
    logic [2:0] cyc_q;
    logic [2:0] cnt_q;
    logic taken_q;
    logic [31:0] rdata_q;

    logic wr_acc;
    logic rd_acc;
    logic addr_ok;
    logic start;
    logic [21:0] pc_d;
    logic [7:0] flags_d;
    logic [2:0] cyc_d;
    logic taken_d;
    logic [15:0] res_d;
    logic [8:0] diff;
    logic [4:0] half;
    logic cin;
    logic [7:0] sub_b;

    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    assign wr_acc = req.sel && req.enable && req.write;
    assign rd_acc = req.sel && !req.enable && !req.write;
    assign start = wr_acc && (req.addr == BSC_OFS_CMD) && (state_q == BSC_ST_IDLE);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // relative target; k is a 12 bit two's complement word offset
    function automatic logic [21:0] rel_target(input logic [21:0] pc, input logic [11:0] k);
        rel_target = pc + {{10{k[11]}}, k} + BSC_PC_STEP;
    endfunction

    // skip distance and cycle count shared by every skip form
    function automatic logic [21:0] skip_pc(input logic [21:0] pc, input logic two_words);
        skip_pc = pc + (two_words ? BSC_PC_SKIP2 : BSC_PC_SKIP1);
    endfunction

    function automatic logic [2:0] skip_cyc(input logic [2:0] base, input logic hit,
                                            input logic two_words);
        skip_cyc = !hit ? base : (two_words ? base + 3'h2 : base + 3'h1);
    endfunction

    // ------------------------------------------------------------
    // decode of one operation
    // ------------------------------------------------------------
    always_comb begin
        logic cond;
        cond = 1'b0;
        pc_d = pc_q + BSC_PC_STEP;
        flags_d = flags_q;
        cyc_d = BSC_CYC_ONE;
        taken_d = 1'b0;
        res_d = res_q;
        cin = 1'b0;
        sub_b = ops_q.rr;
        case (op_q)
            BSC_OP_CMP_BORROW: cin = flags_q[BSC_FLAG_C];
            BSC_OP_CMP_IMM: sub_b = ops_q.k[7:0];
            default: cin = 1'b0;
        endcase
        diff = {1'b0, ops_q.rd} - {1'b0, sub_b} - {8'h00, cin};
        half = {1'b0, ops_q.rd[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, cin};
        case (op_q)
            BSC_OP_INDIRECT_CALL: begin
                pc_d = {6'h00, z_q}; // RQ1
                cyc_d = (PC_W > 16) ? BSC_CYC_THREE : BSC_CYC_TWO; // RQ1
                taken_d = 1'b1;
            end
            BSC_OP_EXT_INDIRECT_CALL: begin
                pc_d = {page_q, z_q}; // RQ2
                cyc_d = BSC_CYC_THREE; // RQ2
                taken_d = 1'b1;
            end
            BSC_OP_REL_CALL: begin
                pc_d = rel_target(pc_q, ops_q.k); // RQ13
                cyc_d = (PC_W > 16) ? BSC_CYC_THREE : BSC_CYC_TWO;
                taken_d = 1'b1;
            end
            BSC_OP_DIRECT_CALL: begin
                pc_d = {10'h000, ops_q.k}; // RQ13
                cyc_d = (PC_W > 16) ? BSC_CYC_FOUR : BSC_CYC_THREE;
                taken_d = 1'b1;
            end
            BSC_OP_SUB_EXIT, BSC_OP_IRQ_EXIT: begin
                pc_d = stack_q; // RQ13
                cyc_d = BSC_CYC_FOUR + ((PC_W > 16) ? 3'h1 : 3'h0);
                taken_d = 1'b1;
                if (op_q == BSC_OP_IRQ_EXIT) begin
                    flags_d[BSC_FLAG_I] = 1'b1; // RQ13
                end
            end
            BSC_OP_CMP_SKIP_EQ, BSC_OP_SKIP_REG_CLR, BSC_OP_SKIP_REG_SET: begin
                if (op_q == BSC_OP_CMP_SKIP_EQ) begin
                    cond = (ops_q.rd == ops_q.rr); // RQ3
                end else begin
                    cond = ops_q.rr[ops_q.bit_sel] == (op_q == BSC_OP_SKIP_REG_SET); // RQ4
                end
                if (cond) begin
                    pc_d = skip_pc(pc_q, ops_q.next_two_words); // RQ3 RQ4
                end
                cyc_d = skip_cyc(BSC_CYC_ONE, cond, ops_q.next_two_words); // RQ3 RQ4
                taken_d = cond;
            end
            BSC_OP_SKIP_IO_CLR, BSC_OP_SKIP_IO_SET: begin
                cond = io_q[ops_q.bit_sel] == (op_q == BSC_OP_SKIP_IO_SET); // RQ5
                if (cond) begin
                    pc_d = skip_pc(pc_q, ops_q.next_two_words); // RQ5
                end
                cyc_d = skip_cyc(BSC_CYC_TWO, cond, ops_q.next_two_words); // RQ5
                taken_d = cond;
            end
            BSC_OP_BR_FLAG_SET, BSC_OP_BR_FLAG_CLR, BSC_OP_BR_SIGNED_GE,
            BSC_OP_BR_SIGNED_LT: begin
                // named branches (carry, zero, minus, h, t, v, i) are flag s forms
                if (op_q == BSC_OP_BR_SIGNED_GE || op_q == BSC_OP_BR_SIGNED_LT) begin
                    cond = (flags_q[BSC_FLAG_N] ^ flags_q[BSC_FLAG_V])
                        == (op_q == BSC_OP_BR_SIGNED_LT); // RQ8
                end else begin
                    cond = flags_q[ops_q.bit_sel]
                        == (op_q == BSC_OP_BR_FLAG_SET); // RQ6 RQ7 RQ9 RQ10 RQ11 RQ12
                end
                if (cond) begin
                    pc_d = rel_target(pc_q, ops_q.k); // RQ6 RQ7 RQ9 RQ10
                end
                cyc_d = cond ? BSC_CYC_TWO : BSC_CYC_ONE; // RQ6 RQ8 RQ12
                taken_d = cond;
            end
            BSC_OP_CMP_REGS, BSC_OP_CMP_BORROW, BSC_OP_CMP_IMM: begin
                flags_d[BSC_FLAG_C] = diff[8]; // RQ14
                flags_d[BSC_FLAG_H] = half[4];
                flags_d[BSC_FLAG_N] = diff[7];
                flags_d[BSC_FLAG_V] = (ops_q.rd[7] ^ sub_b[7]) & (ops_q.rd[7] ^ diff[7]);
                flags_d[BSC_FLAG_S] = diff[7] ^ flags_d[BSC_FLAG_V];
                // with borrow keeps z clear when the previous compare was unequal
                if (op_q == BSC_OP_CMP_BORROW) begin
                    flags_d[BSC_FLAG_Z] = (diff[7:0] == 8'h00) & flags_q[BSC_FLAG_Z];
                end else begin
                    flags_d[BSC_FLAG_Z] = (diff[7:0] == 8'h00);
                end
            end
            BSC_OP_COPY_REG: res_d = {8'h00, ops_q.rr}; // RQ15
            BSC_OP_COPY_PAIR: res_d = {ops_q.rr, ops_q.rd}; // RQ15
            default: pc_d = pc_q + BSC_PC_STEP;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer: idle, then busy for the operation's cycle count
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= BSC_ST_IDLE;
            cnt_q <= 3'h0;
        end else begin
            case (state_q)
                BSC_ST_IDLE: begin
                    if (start) begin
                        state_q <= BSC_ST_BUSY;
                        cnt_q <= 3'h1;
                    end
                end
                BSC_ST_BUSY: begin
                    // cyc_q is only latched at the first busy edge, so use the live count there
                    if (cnt_q >= ((cnt_q == 3'h1) ? cyc_d : cyc_q)) begin
                        state_q <= BSC_ST_DONE;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                BSC_ST_DONE: state_q <= BSC_ST_IDLE;
                default: state_q <= BSC_ST_IDLE;
            endcase
        end
    end

    // latch the result one cycle after start; counting uses it from then on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= BSC_CYC_ONE;
            taken_q <= 1'b0;
        end else if (state_q == BSC_ST_BUSY && cnt_q == 3'h1) begin
            cyc_q <= cyc_d;
            taken_q <= taken_d;
        end
    end

    // ------------------------------------------------------------
    // software state, written over apb; results land at done
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q <= BSC_OP_NONE;
            ops_q <= '0;
            flags_q <= BSC_FLAGS_RST;
            z_q <= 16'h0000;
            page_q <= 6'h00;
            pc_q <= BSC_PC_RST;
            stack_q <= BSC_PC_RST;
            res_q <= 16'h0000;
            io_q <= 8'h00;
        end else if (state_q == BSC_ST_DONE) begin
            pc_q <= pc_d;
            flags_q <= flags_d;
            res_q <= res_d;
        end else if (wr_acc && state_q == BSC_ST_IDLE) begin
            // operands are frozen while an operation runs
            case (req.addr)
                BSC_OFS_CMD: op_q <= bsc_op_t'(req.wdata[5:0]);
                BSC_OFS_OPS: ops_q <= req.wdata[31:0];
                BSC_OFS_FLAGS: flags_q <= req.wdata[7:0];
                BSC_OFS_Z: z_q <= req.wdata[15:0];
                BSC_OFS_PC: pc_q <= req.wdata[21:0];
                BSC_OFS_PAGE: page_q <= req.wdata[5:0];
                BSC_OFS_STACK: stack_q <= req.wdata[21:0];
                BSC_OFS_IO: io_q <= req.wdata[7:0];
                default: io_q <= io_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // apb read path and answer
    // ------------------------------------------------------------
    always_comb begin
        case (req.addr)
            BSC_OFS_CMD, BSC_OFS_OPS, BSC_OFS_FLAGS, BSC_OFS_Z, BSC_OFS_PC, BSC_OFS_PAGE,
            BSC_OFS_STACK, BSC_OFS_RES, BSC_OFS_STATUS, BSC_OFS_IO: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // read data captured in setup so the access phase answers at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
        end else if (rd_acc) begin
            case (req.addr)
                BSC_OFS_CMD: rdata_q <= {26'h0000000, op_q};
                BSC_OFS_OPS: rdata_q <= ops_q;
                BSC_OFS_FLAGS: rdata_q <= {24'h000000, flags_q};
                BSC_OFS_Z: rdata_q <= {16'h0000, z_q};
                BSC_OFS_PC: rdata_q <= {10'h000, pc_q};
                BSC_OFS_PAGE: rdata_q <= {26'h0000000, page_q};
                BSC_OFS_STACK: rdata_q <= {10'h000, stack_q};
                BSC_OFS_RES: rdata_q <= {16'h0000, res_q};
                BSC_OFS_STATUS: rdata_q <= {24'h000000, taken_q, cyc_q, 2'b00, state_q};
                BSC_OFS_IO: rdata_q <= {24'h000000, io_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end
    end

    assign prdata = rdata_q;
    assign pready = 1'b1; // zero wait states
    // unmapped address, or a write while busy, is flagged as an error
    assign pslverr = req.sel && req.enable
        && (!addr_ok || (req.write && state_q != BSC_ST_IDLE));

endmodule

//--- verif/bsc_core_sva.sv
// assertion checker for the apb side of the branch, skip and call control block
`timescale 1ns/10ps
module bsc_core_sva
    import bsc_pkg::*;
#(
    parameter int PC_W = 22
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic acc;
    logic unmapped;
    logic cmd_acc;
    assign acc = psel && penable;
    assign unmapped = (paddr > BSC_OFS_IO) || (paddr[1:0] != 2'h0);
    // opcode zero is left out: it need not start anything
    assign cmd_acc = acc && pwrite && !pslverr && paddr == BSC_OFS_CMD && pwdata[5:0] != 6'h0;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_rdy;
        acc |-> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready low in access phase");
    property p_err_idle;
        !acc |-> !pslverr;
    endproperty
    a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
    property p_err_map;
        acc && unmapped |-> pslverr;
    endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
    property p_rd_zero;
        acc && !pwrite && unmapped |-> prdata == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
    property p_rd_ok;
        acc && !pwrite && !unmapped |-> !pslverr;
    endproperty
    a_rd_ok: assert property (p_rd_ok) else $error("mapped read refused");
    property p_busy_refuse;
        cmd_acc ##2 (acc && pwrite) |-> pslverr;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("write taken while busy");
    property p_hold;
        !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved outside setup");
    property p_busy_status;
        cmd_acc ##2 (acc && !pwrite && paddr == BSC_OFS_STATUS) |-> prdata[0];
    endproperty
    a_busy_status: assert property (p_busy_status) else $error("status idle after start");
endmodule

bind bsc_core bsc_core_sva #(.PC_W(PC_W)) u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

//--- verif/bsc_core_tb.sv
// self-checking testbench for the branch, skip and call control block
`timescale 1ns/10ps
module bsc_core_tb;
    import bsc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [64:0] exp_q[$];
    logic [64:0] note;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    bsc_core #(.PC_W(22)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ------------------------------------------------------------
    // clock, timeout, comparison, verdict
    // ------------------------------------------------------------
    always #12.5 pclk = ~pclk;
    // the run takes about 2100 cycles; a hang ends here
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            bad_count = bad_count + 1;
            print_verdict();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // every finished transfer is matched with the oldest note
    always @(posedge pclk) begin
        if (presetn === 1'b1 && psel && penable && pready === 1'b1) begin
            note = exp_q.pop_front();
            check("prdata", prdata & note[63:32], note[31:0]);
            check("pslverr", {31'h0, pslverr}, {31'h0, note[64]});
        end
    end
    // ------------------------------------------------------------
    // apb master; request held until pready is seen high
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] m, input logic [31:0] e, input logic err);
        exp_q.push_back({err, m, e});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0, m, e, 1'b0);
    endtask
    task automatic gap(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask
    function automatic logic [21:0] rel(input logic [21:0] pc, input logic [11:0] k);
        return pc + {{10{k[11]}}, k} + BSC_PC_STEP;
    endfunction
    // subtract flags; the chained form keeps z only if it was already set
    function automatic logic [7:0] cmpf(input logic [7:0] d, input logic [7:0] r,
            input logic ci, input logic [7:0] f, input logic chain);
        logic [8:0] s;
        logic [4:0] h;
        logic v;
        s = {1'b0, d} - {1'b0, r} - {8'h0, ci};
        h = {1'b0, d[3:0]} - {1'b0, r[3:0]} - {4'h0, ci};
        v = (d[7] & ~r[7] & ~s[7]) | (~d[7] & r[7] & s[7]);
        return {f[7:6], h[4], s[7] ^ v, v, s[7], (s[7:0] == 8'h0) & (f[1] | ~chain), s[8]};
    endfunction
    // load state, start, wait out the longest op, read pc, flags, status {mask,taken}
    task automatic run(input bsc_op_t op, input bsc_ops_t ops, input logic [7:0] fl,
            input logic [21:0] pc0, input logic [21:0] pc1, input logic [7:0] fl1,
            input logic [2:0] cyc, input logic [1:0] tk);
        wr(BSC_OFS_FLAGS, {24'h0, fl});
        wr(BSC_OFS_PC, {10'h0, pc0});
        wr(BSC_OFS_OPS, ops);
        wr(BSC_OFS_CMD, {26'h0, op});
        gap(8);
        rd(BSC_OFS_PC, 32'h3FFFFF, {10'h0, pc1});
        rd(BSC_OFS_FLAGS, 32'hFF, {24'h0, fl1});
        rd(BSC_OFS_STATUS, {24'h0, tk[1], 7'h73}, {24'h0, tk[0], cyc, 4'h0});
        gap(1);
    endtask
    task automatic skip(input bsc_op_t op, input bsc_ops_t o, input logic [21:0] pc,
            input logic tk, input logic [2:0] base);
        run(op, o, 8'h5C, pc, pc + (!tk ? BSC_PC_STEP : o.next_two_words ? BSC_PC_SKIP2 :
            BSC_PC_SKIP1), 8'h5C, base + (tk ? 3'h1 + {2'h0, o.next_two_words} : 3'h0),
            {1'b1, tk});
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        bsc_ops_t o;
        logic [7:0] fl;
        logic [21:0] pc;
        logic tk;
        void'($urandom(60));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(BSC_OFS_PC, 32'hFFFFFFFF, {10'h0, BSC_PC_RST});
        rd(BSC_OFS_FLAGS, 32'hFFFFFFFF, {24'h0, BSC_FLAGS_RST});
        apb(1'b0, 8'h28, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
        apb(1'b1, 8'h2C, 32'h5A, 32'h0, 32'h0, 1'b1);
        o = $urandom;
        o.k[11] = 1'b0;
        fl = 8'($urandom) & 8'h7F;
        pc = 22'($urandom);
        wr(BSC_OFS_Z, {16'h0, 16'hC3A5});
        wr(BSC_OFS_PAGE, 32'h2D);
        gap(1);
        run(BSC_OP_INDIRECT_CALL, o, fl, pc, 22'h00C3A5, fl, 3'h3, 2'h0);
        run(BSC_OP_EXT_INDIRECT_CALL, o, fl, pc, 22'h2DC3A5, fl, 3'h3, 2'h0);
        run(BSC_OP_REL_CALL, o, fl, pc, rel(pc, o.k), fl, 3'h3, 2'h0);
        run(BSC_OP_DIRECT_CALL, o, fl, pc, {10'h0, o.k}, fl, 3'h4, 2'h0);
        for (int i = 0; i < 2; i++) begin
            wr(BSC_OFS_STACK, {10'h0, ~pc});
            run(bsc_op_t'(BSC_OP_SUB_EXIT + i), o, fl, pc, ~pc, fl | {i[0], 7'h0},
                3'h5, 2'h0);
        end
        $display("test calls done");
        for (int i = 0; i < 8; i++) begin
            o = $urandom;
            o.next_two_words = i[0];
            tk = i[1];
            pc = 22'($urandom);
            o.rr = tk ? o.rd : ~o.rd;
            skip(BSC_OP_CMP_SKIP_EQ, o, pc, tk, 3'h1);
            o.rr[o.bit_sel] = (i[2] == tk);
            skip(i[2] ? BSC_OP_SKIP_REG_SET : BSC_OP_SKIP_REG_CLR, o, pc, tk, 3'h1);
            wr(BSC_OFS_IO, {24'h0, o.rr});
            skip(i[2] ? BSC_OP_SKIP_IO_SET : BSC_OP_SKIP_IO_CLR, o, pc, tk, 3'h2);
        end
        $display("test skips done");
        for (int i = 0; i < 40; i++) begin
            o = $urandom;
            o.bit_sel = i[4:2];
            fl = 8'($urandom);
            fl[i[4:2]] = i[0];
            fl[BSC_FLAG_N] = (i < 32) ? fl[BSC_FLAG_N] : i[0];
            tk = (i < 32) ? i[0] ^ i[1] : i[0] ^ fl[BSC_FLAG_V] ^ ~i[1];
            pc = 22'($urandom);
            run((i >= 32) ? bsc_op_t'(BSC_OP_BR_SIGNED_GE + i[1]) : i[1] ? BSC_OP_BR_FLAG_CLR :
                BSC_OP_BR_FLAG_SET, o, fl, pc, tk ? rel(pc, o.k) : pc + BSC_PC_STEP, fl,
                tk ? BSC_CYC_TWO : BSC_CYC_ONE, {1'b1, tk});
        end
        $display("test branches done");
        for (int i = 0; i < 12; i++) begin
            o = $urandom;
            o.rr = (i < 3) ? o.rd : o.rr;
            o.k[7:0] = (i < 3) ? o.rd : o.k[7:0];
            fl = 8'($urandom);
            pc = 22'($urandom);
            run(bsc_op_t'(BSC_OP_CMP_REGS + i % 3), o, fl, pc, pc + BSC_PC_STEP, cmpf(o.rd,
                (i % 3 == 2) ? o.k[7:0] : o.rr, (i % 3 == 1) & fl[0], fl, i % 3 == 1), 3'h1, 2'h0);
        end
        for (int i = 0; i < 4; i++) begin
            o = $urandom;
            run(i[0] ? BSC_OP_COPY_PAIR : BSC_OP_COPY_REG, o, 8'hA6, pc,
                pc + 22'h1, 8'hA6, 3'h1, 2'h0);
            rd(BSC_OFS_RES, 32'hFFFFFFFF, i[0] ? {16'h0, o.rr, o.rd} : {24'h0, o.rr});
            gap(1);
        end
        $display("test compares and copies done");
        // writes during a long command are refused and leave the flags alone
        for (int i = 0; i < 2; i++) begin
            wr(BSC_OFS_FLAGS, 32'h3C);
            wr(BSC_OFS_STACK, {10'h0, pc});
            wr(BSC_OFS_CMD, {26'h0, BSC_OP_SUB_EXIT});
            if (i == 0) rd(BSC_OFS_STATUS, 32'h1, 32'h1);
            apb(1'b1, BSC_OFS_FLAGS, 32'hC3, 32'h0, 32'h0, 1'b1);
            if (i == 1) rd(BSC_OFS_STATUS, 32'h1, 32'h1);
            gap(8);
            rd(BSC_OFS_FLAGS, 32'hFF, 32'h3C);
            rd(BSC_OFS_PC, 32'h3FFFFF, {10'h0, pc});
        end
        gap(1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(BSC_OFS_PC, 32'hFFFFFFFF, {10'h0, BSC_PC_RST});
        gap(2);
        $display("test refusal and reset done");
        print_verdict();
    end
endmodule
